// ---- beacon_pkg.sv ----
// package: constants and types for the beacon field builder
package beacon_pkg;
    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] CMD_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] COUNT_ADDR = 8'h0c;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int CTRL_PERMIT_BIT = 0;
    localparam int CTRL_COORD_BIT = 1;
    localparam int CMD_BUILD_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_PEND_BIT = 1;
    localparam int STATUS_LVL_LSB = 4;
    // superframe specification field positions
    localparam int SF_BO_LSB = 0;
    localparam int SF_SO_LSB = 4;
    localparam int SF_CAP_LSB = 8;
    localparam int SF_BLE_BIT = 12;
    localparam int SF_COORD_BIT = 14;
    localparam int SF_PERMIT_BIT = 15;
    localparam logic [3:0] SF_BO_VAL = 4'h0;
    localparam logic [3:0] SF_SO_VAL = 4'h0;
    localparam logic [3:0] SF_CAP_VAL = 4'h0;
    localparam logic SF_BLE_VAL = 1'b0;
    // gts specification field positions
    localparam int GTS_CNT_LSB = 0;
    localparam int GTS_PERMIT_BIT = 7;
    localparam logic [2:0] GTS_CNT_VAL = 3'h0;
    localparam logic GTS_PERMIT_VAL = 1'b0;
    // output buffer
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W = 4;
    // one output byte with its end-of-fields mark
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } fbyte_s;
    localparam int FBYTE_W = 9;
    // builder states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SF_LO = 4'h2,
        ST_SF_HI = 4'h4,
        ST_GTS = 4'h8
    } build_e;
endpackage

// ---- beacon_frame_field_builder.sv ----
// beacon field builder: fixed superframe and gts fields into a byte fifo
//
// Overview of operation
// - beacons built only on request, no timer
// - beacon order subfield always zero
// - superframe order subfield always zero
// - final cap slot subfield always zero
// - battery life extension bit always zero
// - association permit from upper layer setting
// - gts descriptor count always zero
// - gts permit bit always zero
// - no gts direction byte emitted
// - gts list empty, zero bytes
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// byte fifo
// ----------------------------------------
module fbyte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8,
    parameter int LVL_W = 4
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [LVL_W-1:0] level
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [LVL_W-1:0] cnt_ff;
    wire push;
    wire pop;

    // next pointer, wrapping after the last slot
    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // handshakes and flags
    // full at depth entries: in_ready drops and the writer waits
    assign in_ready = (cnt_ff != LVL_W'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // head entry comes straight from the array and holds while nothing pops
    assign out_data = mem[rd_ptr_ff];
    assign level = cnt_ff;

    // storage
    // the array is not reset; its contents mean nothing while the count is zero
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ptr_next(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= ptr_next(rd_ptr_ff);
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------
// field builder top
// ----------------------------------------
module beacon_frame_field_builder
    import beacon_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic beacon_req,
    input wire logic assoc_permit,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_last,
    output logic busy
);
    // --------------------------------
    // field packing
    // --------------------------------
    // builds the 16-bit superframe specification
    // bit 13 is reserved and left at zero
    function automatic logic [15:0] sf_spec(input logic coord, input logic permit);
        logic [15:0] v;
        v = 16'h0000;
        v[SF_BO_LSB +: 4] = SF_BO_VAL;
        v[SF_SO_LSB +: 4] = SF_SO_VAL;
        v[SF_CAP_LSB +: 4] = SF_CAP_VAL;
        v[SF_BLE_BIT] = SF_BLE_VAL;
        v[SF_COORD_BIT] = coord;
        v[SF_PERMIT_BIT] = permit;
        return v;
    endfunction

    // builds the one-byte gts specification
    function automatic logic [7:0] gts_spec();
        logic [7:0] v;
        v = 8'h00;
        v[GTS_CNT_LSB +: 3] = GTS_CNT_VAL;
        v[GTS_PERMIT_BIT] = GTS_PERMIT_VAL;
        return v;
    endfunction

    // --------------------------------
    // registers and wires
    // --------------------------------
    logic [1:0] ctrl_ff;
    logic pend_ff;
    logic [15:0] count_ff;
    logic [15:0] sf_ff;
    logic [DATA_W-1:0] rdata_ff;
    build_e state_ff;
    build_e nxt_state;
    // buffer side of the sequencer
    fbyte_s fifo_in;
    fbyte_s fifo_out;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [LVL_W-1:0] fifo_level;

    // --------------------------------
    // request and register decode
    // --------------------------------
    // address decode shared by writes and reads
    wire sel_ctrl = (addr == CTRL_ADDR);
    wire sel_cmd = (addr == CMD_ADDR);
    wire sel_status = (addr == STATUS_ADDR);
    wire sel_count = (addr == COUNT_ADDR);
    wire ctrl_wr = wr && sel_ctrl;
    wire cmd_build = wr && sel_cmd && wdata[CMD_BUILD_BIT];
    // requests come only from the pin or the command register, never a timer
    wire new_req = cmd_build || beacon_req;
    wire start = (state_ff == ST_IDLE) && (pend_ff || new_req);
    // a request that meets a busy builder or an older pending one is kept
    wire hold_req = new_req && ((state_ff != ST_IDLE) || pend_ff);
    wire permit_now = assoc_permit || ctrl_ff[CTRL_PERMIT_BIT];
    wire byte_taken = fifo_in_valid && fifo_in_ready;
    wire done = (state_ff == ST_GTS) && byte_taken;
    // read words, zero above the defined fields
    wire [DATA_W-1:0] ctrl_word = {{(DATA_W - 2){1'b0}}, ctrl_ff};
    wire [DATA_W-1:0] count_word = {{(DATA_W - 16){1'b0}}, count_ff};
    wire [DATA_W-1:0] status_word = {{(DATA_W - STATUS_LVL_LSB - LVL_W){1'b0}}, fifo_level,
        2'h0, pend_ff, busy};
    wire [DATA_W-1:0] rd_mux =
        sel_ctrl ? ctrl_word :
        sel_status ? status_word :
        sel_count ? count_word :
        {DATA_W{1'b0}};

    // --------------------------------
    // byte sequencer
    // --------------------------------
    // byte order: sf low, sf high, gts; nothing after gts
    always_comb begin
        nxt_state = state_ff;
        fifo_in_valid = 1'b0;
        fifo_in = '0;
        case (state_ff)
            ST_IDLE: begin
                // waits here until a request arrives
                if (start) begin
                    nxt_state = ST_SF_LO;
                end
            end
            ST_SF_LO: begin
                fifo_in_valid = 1'b1;
                fifo_in.data = sf_ff[7:0];
                if (fifo_in_ready) begin
                    nxt_state = ST_SF_HI;
                end
            end
            ST_SF_HI: begin
                fifo_in_valid = 1'b1;
                fifo_in.data = sf_ff[15:8];
                if (fifo_in_ready) begin
                    nxt_state = ST_GTS;
                end
            end
            ST_GTS: begin
                fifo_in_valid = 1'b1;
                fifo_in.data = gts_spec();
                // the gts byte closes the set; no direction or list bytes follow
                fifo_in.last = 1'b1;
                if (fifo_in_ready) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // --------------------------------
    // state and pending request
    // --------------------------------
    // state register and field snapshot
    // permit and coordinator are frozen at the start edge so all bytes agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            sf_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            if (start) begin
                sf_ff <= sf_spec(ctrl_ff[CTRL_COORD_BIT], permit_now);
            end
        end
    end

    // pending request: a kept request wins over the start that consumes the older one,
    // so a request in the very cycle a pending build starts is not lost
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pend_ff <= 1'b0;
        end else if (hold_req) begin
            pend_ff <= 1'b1;
        end else if (start) begin
            pend_ff <= 1'b0;
        end
    end

    // --------------------------------
    // register port
    // --------------------------------
    // control, beacon count and read data
    // the beacon count wraps silently at 16 bits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= CTRL_RESET;
            count_ff <= 16'h0000;
            rdata_ff <= '0;
        end else begin
            if (ctrl_wr) begin
                ctrl_ff <= wdata[1:0];
            end
            if (done) begin
                count_ff <= count_ff + 16'h0001;
            end
            rdata_ff <= rd ? rd_mux : '0;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    assign rdata = rdata_ff;
    assign busy = (state_ff != ST_IDLE);

    // --------------------------------
    // output buffer
    // --------------------------------
    fbyte_fifo #(
        .WIDTH(FBYTE_W),
        .DEPTH(FIFO_DEPTH),
        .LVL_W(LVL_W)
    ) u_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    // unpack the head entry onto the sink side
    assign out_data = fifo_out.data;
    assign out_last = fifo_out.last;
endmodule

`default_nettype wire

// ---- beacon_field_asserts.sv ----
// checker for the beacon field byte stream and the register port
`timescale 1ns/1ps
`default_nettype none
module beacon_field_asserts
    import beacon_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic beacon_req,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    input wire logic busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [1:0] idx_ff;
    logic take;
    logic cmd_wr;
    // ----------------------------------------
    // byte position tracking
    // ----------------------------------------
    assign take = out_valid && out_ready;
    assign cmd_wr = wr && addr == CMD_ADDR && wdata[0];
    // position of the head byte inside its beacon
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idx_ff <= 2'h0;
        end else if (take) begin
            idx_ff <= (idx_ff == 2'h2) ? 2'h0 : idx_ff + 2'h1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_build_cause: assert property ($rose(busy) |-> $past(beacon_req) || $past(cmd_wr) || $past(busy, 2))
        else $error("busy rose without a request");
    a_lo_zero: assert property (out_valid && idx_ff == 2'h0 |-> out_data == 8'h00)
        else $error("superframe low byte not zero");
    a_hi_low_zero: assert property (out_valid && idx_ff == 2'h1 |-> out_data[5:0] == 6'h00)
        else $error("superframe high byte low bits not zero");
    a_gts_zero: assert property (out_valid && idx_ff == 2'h2 |-> out_data == 8'h00 && out_last)
        else $error("gts byte wrong");
    a_last_only_gts: assert property (out_valid && idx_ff != 2'h2 |-> !out_last)
        else $error("end mark before third byte");
    a_hold_stall: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
        else $error("head byte changed under stall");
    a_three_push: assert property ($rose(busy) |-> busy [*3])
        else $error("build shorter than three bytes");
    a_rdata_gap: assert property (!rd |=> rdata == 32'h0)
        else $error("read data outside answer cycle");
    c_beacon: cover property ($rose(busy));
    c_stall: cover property (out_valid && !out_ready && busy);
    c_last: cover property (take && out_last);
endmodule
bind beacon_frame_field_builder beacon_field_asserts u_chk (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
    .beacon_req, .out_valid, .out_ready, .out_data, .out_last, .busy);
`default_nettype wire

// ---- frame_sink_model.sv ----
// model of the downstream frame assembler taking bytes with random stalls
`timescale 1ns/1ps
`default_nettype none
module frame_sink_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic stall,
    output logic out_ready
);
    // ready drops at random, and stays low while told to stall
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall && ($urandom % 4 != 0);
        end
    end
endmodule
`default_nettype wire

// ---- beacon_frame_field_builder_tb.sv ----
// testbench: drives requests and registers, scoreboards bytes and reads
`timescale 1ns/1ps
`default_nettype none
module beacon_frame_field_builder_tb;
    import beacon_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic beacon_req = 1'b0;
    logic assoc_permit = 1'b0;
    logic stall = 1'b0;
    logic rd_d = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic out_valid;
    logic out_ready;
    logic [7:0] out_data;
    logic out_last;
    logic busy;
    fbyte_s exp_q[$];
    logic [DATA_W-1:0] rexp_q[$];
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int beacons = 0;
    // 20 MHz clock
    initial forever #25 ref_clk = ~ref_clk;
    beacon_frame_field_builder DUT (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .beacon_req,
        .assoc_permit, .out_valid, .out_ready, .out_data, .out_last, .busy);
    frame_sink_model sink (.ref_clk, .resetn, .stall, .out_ready);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        rexp_q.push_back(d);
        @(posedge ref_clk);
        rd <= 1'b0;
    endtask
    task automatic expect_beacon(logic permit, logic coord);
        exp_q.push_back('{8'h00, 1'b0});
        exp_q.push_back('{{permit, coord, 6'h00}, 1'b0});
        exp_q.push_back('{8'h00, 1'b1});
        beacons++;
    endtask
    task automatic pulse_req();
        @(posedge ref_clk);
        beacon_req <= 1'b1;
        @(posedge ref_clk);
        beacon_req <= 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        for (int i = 0; i < 400 && n < 3; i++) begin
            @(posedge ref_clk);
            n = (busy === 1'b0 && out_valid === 1'b0) ? n + 1 : 0;
        end
    endtask
    // scoreboard: oldest note against each byte taken and each read answer
    always @(posedge ref_clk) begin
        if (resetn && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) check("extra byte", 32'h0, 32'h1);
            else check("out byte", exp_q.pop_front(), {out_data, out_last});
        end
        if (rd_d) check("rdata", rexp_q.pop_front(), rdata);
        rd_d <= rd;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h54a0));
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_reg(CTRL_ADDR, 32'h0);
        rd_reg(8'h10, 32'h0);
        rd_reg(COUNT_ADDR, 32'h0);
        // every control register setting of permit and coordinator, with a random assoc_permit, by pin and by command
        for (int i = 0; i < 8; i++) begin
            logic p;
            p = 1'($urandom % 2);
            wr_reg(CTRL_ADDR, {30'h0, i[1:0]});
            assoc_permit <= p;
            expect_beacon(p | i[0], i[1]);
            if (i[2]) wr_reg(CMD_ADDR, 32'h1);
            else pulse_req();
            wait_idle();
        end
        // three requests in a row: one builds, the rest merge into one
        wr_reg(CTRL_ADDR, 32'h0);
        assoc_permit <= 1'b0;
        beacon_req <= 1'b1;
        expect_beacon(1'b0, 1'b0);
        expect_beacon(1'b0, 1'b0);
        repeat (2) @(posedge ref_clk);
        beacon_req <= 1'b0;
        wr_reg(CMD_ADDR, 32'h1);
        wait_idle();
        // stalled sink fills the buffer and stops the builder
        stall <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            pulse_req();
            expect_beacon(1'b0, 1'b0);
            repeat (8) @(posedge ref_clk);
        end
        rd_reg(STATUS_ADDR, 32'h81);
        stall <= 1'b0;
        wait_idle();
        rd_reg(COUNT_ADDR, 32'(beacons));
        repeat (300) @(posedge ref_clk);
        rd_reg(COUNT_ADDR, 32'(beacons));
        repeat (2) @(posedge ref_clk);
        check("bytes left", 32'h0, 32'(exp_q.size()));
        print_verdict();
    end
endmodule
`default_nettype wire
